// >>> core/ssp_pkg.sv
// constants, field layout and types of the synchronous serial port
`default_nettype none
package ssp_pkg;
	localparam int unsigned SSP_AW        = 5;
	localparam logic [4:0]  SSP_CTRL0_OFF = 5'h00;
	localparam logic [4:0]  SSP_CTRL1_OFF = 5'h04;
	localparam logic [4:0]  SSP_DATA_OFF  = 5'h08;
	localparam logic [4:0]  SSP_STAT_OFF  = 5'h0C;
	localparam logic [4:0]  SSP_PRESC_OFF = 5'h10;
	// ctrl0 fields
	localparam int unsigned SSP_C0_SIZE   = 0;
	localparam int unsigned SSP_C0_FMT    = 4;
	localparam int unsigned SSP_C0_CPOL   = 6;
	localparam int unsigned SSP_C0_CPHA   = 7;
	localparam int unsigned SSP_C0_SCR    = 8;
	// ctrl1 fields
	localparam int unsigned SSP_C1_EN     = 1;
	localparam int unsigned SSP_C1_SLAVE  = 2;
	localparam int unsigned SSP_C1_SOD    = 3;
	// status fields
	localparam int unsigned SSP_ST_TFE    = 0;
	localparam int unsigned SSP_ST_TNF    = 1;
	localparam int unsigned SSP_ST_RNE    = 2;
	localparam int unsigned SSP_ST_RFF    = 3;
	localparam int unsigned SSP_ST_BSY    = 4;
	localparam int unsigned SSP_ST_OVR    = 5;
	// reset values
	localparam logic [15:0] SSP_CTRL0_RST = 16'h0007;
	localparam logic [3:0]  SSP_CTRL1_RST = 4'h0;
	localparam logic [7:0]  SSP_PRESC_RST = 8'h02;
	// sizes and response codes
	localparam int unsigned SSP_DW        = 16;
	localparam int unsigned SSP_DEPTH     = 8;
	localparam int unsigned SSP_PW        = 3;
	localparam logic [4:0]  SSP_MIN_BITS  = 5'h04;
	localparam logic [4:0]  SSP_CMD_BITS  = 5'h08;
	localparam logic [1:0]  SSP_RESP_OK   = 2'h0;
	localparam logic [1:0]  SSP_RESP_ERR  = 2'h2;

	typedef enum logic [1:0] {
		SSP_FMT_SPI  = 2'h0,
		SSP_FMT_SYNC = 2'h1,
		SSP_FMT_CMD  = 2'h2
	} ssp_fmt_t;

	typedef enum logic [3:0] {
		SSP_S_IDLE  = 4'h1,
		SSP_S_LEAD  = 4'h2,
		SSP_S_SHIFT = 4'h4,
		SSP_S_GAP   = 4'h8
	} ssp_state_t;

	// bits per frame from the size field, clamped to the legal minimum
	function automatic logic [4:0] ssp_bits(input logic [3:0] size_m1);
		logic [4:0] n;
		n = {1'b0, size_m1} + 5'h01;
		return (n < SSP_MIN_BITS) ? SSP_MIN_BITS : n;
	endfunction
endpackage
`default_nettype wire

// >>> core/ssp_fifo_if.sv
// valid/ready carrier between the port engine and its word queues
`timescale 1ns/1ps
`default_nettype none
interface ssp_fifo_if;
	logic        wr_valid;
	logic        wr_ready;
	logic [15:0] wr_data;
	logic        rd_valid;
	logic        rd_ready;
	logic [15:0] rd_data;
	modport store (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
	modport user  (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
endinterface
`default_nettype wire

// >>> core/ssp_fifo.sv
// eight-word queue used for both directions of the port
`timescale 1ns/1ps
`default_nettype none
module ssp_fifo (
	input  wire logic   clock_in,
	input  wire logic   rst_b_in,
	ssp_fifo_if.store   q
);
	import ssp_pkg::*;

	logic [SSP_DW-1:0] mem [SSP_DEPTH];
	logic [SSP_PW:0]   wptr_r;
	logic [SSP_PW:0]   rptr_r;
	logic              full;
	logic              empty;

	assign empty      = (wptr_r == rptr_r);
	assign full       = (wptr_r[SSP_PW] != rptr_r[SSP_PW]) && (wptr_r[SSP_PW-1:0] == rptr_r[SSP_PW-1:0]);
	assign q.wr_ready = !full;
	assign q.rd_valid = !empty;
	assign q.rd_data  = mem[rptr_r[SSP_PW-1:0]];

	always_ff @(posedge clock_in) begin
		if (q.wr_valid && !full) begin
			mem[wptr_r[SSP_PW-1:0]] <= q.wr_data;
		end
	end

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wptr_r <= '0;
			rptr_r <= '0;
		end else begin
			if (q.wr_valid && !full) begin
				wptr_r <= wptr_r + 1'b1;
			end
			if (q.rd_ready && !empty) begin
				rptr_r <= rptr_r + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> core/ssp_top.sv
// synchronous serial port with axi4-lite register access
`timescale 1ns/1ps
`default_nettype none
module ssp_top (
	input  wire logic        clock_in,
	input  wire logic        rst_b_in,
	input  wire logic        s_axi_awvalid_in,
	output logic             s_axi_awready_out,
	input  wire logic [4:0]  s_axi_awaddr_in,
	input  wire logic        s_axi_wvalid_in,
	output logic             s_axi_wready_out,
	input  wire logic [31:0] s_axi_wdata_in,
	input  wire logic [3:0]  s_axi_wstrb_in,
	output logic             s_axi_bvalid_out,
	input  wire logic        s_axi_bready_in,
	output logic [1:0]       s_axi_bresp_out,
	input  wire logic        s_axi_arvalid_in,
	output logic             s_axi_arready_out,
	input  wire logic [4:0]  s_axi_araddr_in,
	output logic             s_axi_rvalid_out,
	input  wire logic        s_axi_rready_in,
	output logic [31:0]      s_axi_rdata_out,
	output logic [1:0]       s_axi_rresp_out,
	input  wire logic        sclk_in,
	output logic             sclk_out,
	output logic             sclk_oe_out,
	input  wire logic        fss_in,
	output logic             fss_out,
	output logic             fss_oe_out,
	input  wire logic        rxd_in,
	output logic             txd_out,
	output logic             txd_oe_out
);
	import ssp_pkg::*;

	ssp_fifo_if tx_if();
	ssp_fifo_if rx_if();

	ssp_fifo u_tx (.clock_in(clock_in), .rst_b_in(rst_b_in), .q(tx_if));
	ssp_fifo u_rx (.clock_in(clock_in), .rst_b_in(rst_b_in), .q(rx_if));

	logic [15:0] ctrl0_r;
	logic [3:0]  ctrl1_r;
	logic [7:0]  presc_r;
	logic        ovr_r;
	logic        aw_hold_r;
	logic        w_hold_r;
	logic [4:0]  aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0]  w_strb_r;
	logic        wr_go;
	logic        ar_hs;
	logic [2:0]  sclk_sy_r;
	logic [1:0]  fss_sy_r;
	logic [1:0]  rxd_sy_r;
	ssp_state_t  state_r;
	logic [5:0]  h_r;
	logic [15:0] div_r;
	logic [15:0] tx_sh_r;
	logic [15:0] rx_sh_r;
	logic [15:0] rx_word_r;
	logic        push_r;

	// decoded configuration
	ssp_fmt_t    fmt;
	logic [4:0]  nbits;
	logic [4:0]  tot;
	logic [5:0]  last;
	logic        cpol_e;
	logic        cpha_e;
	logic        en;
	logic        slave;
	logic [15:0] half_lim;
	logic        tick;
	logic        s_edge;
	logic        s_fall;
	logic        step;
	logic        capture;
	logic        start;
	logic [15:0] txw;
	logic [15:0] cap_word;
	logic [15:0] mask;

	assign fmt      = ssp_fmt_t'(ctrl0_r[SSP_C0_FMT +: 2]);
	assign nbits    = ssp_bits(ctrl0_r[SSP_C0_SIZE +: 4]);
	assign tot      = (fmt == SSP_FMT_CMD) ? (SSP_CMD_BITS + nbits) : nbits;
	assign last     = {tot, 1'b0} - 6'h01;
	assign cpol_e   = (fmt == SSP_FMT_SPI) ? ctrl0_r[SSP_C0_CPOL] : 1'b0;
	assign cpha_e   = (fmt == SSP_FMT_SPI) ? ctrl0_r[SSP_C0_CPHA] : (fmt == SSP_FMT_SYNC);
	assign en       = ctrl1_r[SSP_C1_EN];
	assign slave    = ctrl1_r[SSP_C1_SLAVE];
	// half bit period = prescale/2 * (1 + scr) module clocks
	assign half_lim = 16'({9'h000, presc_r[7:1]} * {8'h00, ctrl0_r[SSP_C0_SCR +: 8]} + {9'h000, presc_r[7:1]}) - 16'h0001;
	assign tick     = (div_r >= half_lim);
	assign s_edge   = sclk_sy_r[2] ^ sclk_sy_r[1];
	assign s_fall   = sclk_sy_r[2] & ~sclk_sy_r[1];
	assign step     = slave ? s_edge : tick;
	assign capture  = (h_r[0] == cpha_e);
	assign start    = en && (slave ? ((fmt == SSP_FMT_SYNC) ? (fss_sy_r[1] && s_fall) : !fss_sy_r[1])
	                               : tx_if.rd_valid);
	assign txw      = !tx_if.rd_valid ? 16'h0000
	                : (fmt == SSP_FMT_CMD) ? {tx_if.rd_data[7:0], 8'h00}
	                : (tx_if.rd_data << (5'h10 - nbits));
	assign mask     = 16'hFFFF >> (5'h10 - nbits);
	assign cap_word = capture ? {rx_sh_r[14:0], rxd_sy_r[1]} : rx_sh_r;

	assign tx_if.wr_valid = wr_go && (aw_addr_r == SSP_DATA_OFF) && (|w_strb_r[1:0]);
	assign tx_if.wr_data  = w_data_r[15:0];
	assign tx_if.rd_ready = (state_r == SSP_S_IDLE) && start;
	assign rx_if.wr_valid = push_r;
	assign rx_if.wr_data  = rx_word_r;
	assign rx_if.rd_ready = ar_hs && (s_axi_araddr_in == SSP_DATA_OFF);

	// pin inputs pass two flops, sclk three; logic reads the second stage, sclk edges compare the second and third
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sclk_sy_r <= 3'h0;
			fss_sy_r  <= 2'h3;
			rxd_sy_r  <= 2'h0;
		end else begin
			sclk_sy_r <= {sclk_sy_r[1:0], sclk_in};
			fss_sy_r  <= {fss_sy_r[0], fss_in};
			rxd_sy_r  <= {rxd_sy_r[0], rxd_in};
		end
	end

	// bit-rate divider, held clear while the engine is idle
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			div_r <= 16'h0000;
		end else if (state_r == SSP_S_IDLE || tick) begin
			div_r <= 16'h0000;
		end else begin
			div_r <= div_r + 16'h0001;
		end
	end

	// frame engine; config changes mid-frame are not guarded, software must idle first
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_r   <= SSP_S_IDLE;
			h_r       <= 6'h00;
			tx_sh_r   <= 16'h0000;
			rx_sh_r   <= 16'h0000;
			rx_word_r <= 16'h0000;
			push_r    <= 1'b0;
			sclk_out  <= 1'b0;
			fss_out   <= 1'b1;
			txd_out   <= 1'b0;
		end else begin
			push_r <= 1'b0;
			case (state_r)
				SSP_S_IDLE: begin
					sclk_out <= cpol_e;
					fss_out  <= (fmt != SSP_FMT_SYNC);
					h_r      <= 6'h00;
					if (start) begin
						tx_sh_r <= txw;
						txd_out <= txw[15];
						state_r <= slave ? SSP_S_SHIFT : SSP_S_LEAD;
						if (!slave) begin
							fss_out <= (fmt == SSP_FMT_SYNC);
						end
					end
				end
				SSP_S_LEAD: begin
					if (tick) begin
						// frame pulse spans one full clock period before the data
						if (fmt == SSP_FMT_SYNC) begin
							sclk_out <= ~sclk_out;
						end
						if (h_r[0]) begin
							h_r     <= 6'h00;
							state_r <= SSP_S_SHIFT;
							fss_out <= 1'b0;
						end else begin
							h_r <= 6'h01;
						end
					end
				end
				SSP_S_SHIFT: begin
					if (slave && fmt != SSP_FMT_SYNC && fss_sy_r[1]) begin
						state_r <= SSP_S_IDLE;
					end else if (step) begin
						if (!slave) begin
							sclk_out <= ~sclk_out;
						end
						if (capture) begin
							rx_sh_r <= cap_word;
						end else if (!(h_r == 6'h00 && cpha_e)) begin
							tx_sh_r <= {tx_sh_r[14:0], 1'b0};
							txd_out <= tx_sh_r[14];
						end
						if (h_r == last) begin
							rx_word_r <= cap_word & mask;
							push_r    <= 1'b1;
							state_r   <= SSP_S_GAP;
						end else begin
							h_r <= h_r + 6'h01;
						end
					end
				end
				SSP_S_GAP: begin
					if (slave ? (fmt == SSP_FMT_SYNC || fss_sy_r[1]) : tick) begin
						fss_out <= (fmt != SSP_FMT_SYNC);
						state_r <= SSP_S_IDLE;
					end
				end
				default: begin
					state_r <= SSP_S_IDLE;
				end
			endcase
		end
	end

	// pin enables
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sclk_oe_out <= 1'b0;
			fss_oe_out  <= 1'b0;
			txd_oe_out  <= 1'b0;
		end else begin
			sclk_oe_out <= en && !slave;
			fss_oe_out  <= en && !slave;
			// a disabled slave output lets several slaves share the master's input line
			txd_oe_out  <= en && (!slave || (state_r != SSP_S_IDLE && !ctrl1_r[SSP_C1_SOD]));
		end
	end

	// overrun: receive queue full drops the new word, stored data is kept
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ovr_r <= 1'b0;
		end else if (push_r && !rx_if.wr_ready) begin
			ovr_r <= 1'b1;
		end else if (wr_go && aw_addr_r == SSP_STAT_OFF && w_strb_r[0] && w_data_r[SSP_ST_OVR]) begin
			ovr_r <= 1'b0;
		end
	end

	// axi write channels, taken in either order
	assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid_out;

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			aw_hold_r         <= 1'b0;
			w_hold_r          <= 1'b0;
			aw_addr_r         <= 5'h00;
			w_data_r          <= 32'h00000000;
			w_strb_r          <= 4'h0;
			s_axi_awready_out <= 1'b1;
			s_axi_wready_out  <= 1'b1;
			s_axi_bvalid_out  <= 1'b0;
			s_axi_bresp_out   <= SSP_RESP_OK;
		end else begin
			if (s_axi_awvalid_in && s_axi_awready_out) begin
				aw_hold_r         <= 1'b1;
				aw_addr_r         <= s_axi_awaddr_in;
				s_axi_awready_out <= 1'b0;
			end
			if (s_axi_wvalid_in && s_axi_wready_out) begin
				w_hold_r         <= 1'b1;
				w_data_r         <= s_axi_wdata_in;
				w_strb_r         <= s_axi_wstrb_in;
				s_axi_wready_out <= 1'b0;
			end
			if (wr_go) begin
				aw_hold_r         <= 1'b0;
				w_hold_r          <= 1'b0;
				s_axi_awready_out <= 1'b1;
				s_axi_wready_out  <= 1'b1;
				s_axi_bvalid_out  <= 1'b1;
				s_axi_bresp_out   <= (aw_addr_r > SSP_PRESC_OFF || aw_addr_r[1:0] != 2'h0) ? SSP_RESP_ERR : SSP_RESP_OK;
			end else if (s_axi_bvalid_out && s_axi_bready_in) begin
				s_axi_bvalid_out <= 1'b0;
			end
		end
	end

	// software registers
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ctrl0_r <= SSP_CTRL0_RST;
			ctrl1_r <= SSP_CTRL1_RST;
			presc_r <= SSP_PRESC_RST;
		end else if (wr_go) begin
			if (aw_addr_r == SSP_CTRL0_OFF) begin
				if (w_strb_r[0]) begin
					ctrl0_r[7:0] <= w_data_r[7:0];
				end
				if (w_strb_r[1]) begin
					ctrl0_r[15:8] <= w_data_r[15:8];
				end
			end
			if (aw_addr_r == SSP_CTRL1_OFF && w_strb_r[0]) begin
				ctrl1_r <= w_data_r[3:0];
			end
			// odd prescale values would break the half-period split, so bit 0 stays clear
			if (aw_addr_r == SSP_PRESC_OFF && w_strb_r[0]) begin
				presc_r <= (w_data_r[7:1] == 7'h00) ? SSP_PRESC_RST : {w_data_r[7:1], 1'b0};
			end
		end
	end

	// axi read channel; reading data pops the receive queue
	assign ar_hs = s_axi_arvalid_in && s_axi_arready_out;

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s_axi_arready_out <= 1'b1;
			s_axi_rvalid_out  <= 1'b0;
			s_axi_rdata_out   <= 32'h00000000;
			s_axi_rresp_out   <= SSP_RESP_OK;
		end else if (ar_hs) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out  <= 1'b1;
			s_axi_rresp_out   <= SSP_RESP_OK;
			case (s_axi_araddr_in)
				SSP_CTRL0_OFF: s_axi_rdata_out <= {16'h0000, ctrl0_r};
				SSP_CTRL1_OFF: s_axi_rdata_out <= {28'h0000000, ctrl1_r};
				SSP_DATA_OFF:  s_axi_rdata_out <= {16'h0000, rx_if.rd_valid ? rx_if.rd_data : 16'h0000};
				SSP_STAT_OFF:  s_axi_rdata_out <= {26'h0000000, ovr_r,
				                                   (state_r != SSP_S_IDLE) || tx_if.rd_valid,
				                                   !rx_if.wr_ready, rx_if.rd_valid,
				                                   tx_if.wr_ready, !tx_if.rd_valid};
				SSP_PRESC_OFF: s_axi_rdata_out <= {24'h000000, presc_r};
				default: begin
					s_axi_rdata_out <= 32'h00000000;
					s_axi_rresp_out <= SSP_RESP_ERR;
				end
			endcase
		end else if (s_axi_rvalid_out && s_axi_rready_in) begin
			s_axi_rvalid_out  <= 1'b0;
			s_axi_arready_out <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// >>> verif/ssp_properties.sv
// port assertions for the synchronous serial port
`timescale 1ns/1ps
`default_nettype none
module ssp_properties (
	input wire logic        clock_in,
	input wire logic        rst_b_in,
	input wire logic        s_axi_awvalid_in,
	input wire logic        s_axi_awready_out,
	input wire logic        s_axi_wvalid_in,
	input wire logic        s_axi_wready_out,
	input wire logic        s_axi_bvalid_out,
	input wire logic        s_axi_bready_in,
	input wire logic [1:0]  s_axi_bresp_out,
	input wire logic        s_axi_arvalid_in,
	input wire logic        s_axi_arready_out,
	input wire logic [4:0]  s_axi_araddr_in,
	input wire logic        s_axi_rvalid_out,
	input wire logic        s_axi_rready_in,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic [1:0]  s_axi_rresp_out,
	input wire logic        sclk_out,
	input wire logic        sclk_oe_out,
	input wire logic        fss_oe_out
);
	import ssp_pkg::*;
	logic take_w;
	logic take_r;
	logic bad_a;
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rst_b_in);
	assign take_w = s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
	assign take_r = s_axi_arvalid_in && s_axi_arready_out;
	// unaligned or past the last register is refused
	assign bad_a = (s_axi_araddr_in > 5'h10) || (s_axi_araddr_in[1:0] != 2'h0);
	a_write_answer: assert property (take_w |=> !s_axi_bvalid_out ##1 s_axi_bvalid_out)
		else $error("write response off time");
	a_write_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
		else $error("write response not held");
	a_write_close: assert property (s_axi_bvalid_out && s_axi_bready_in |=>
		!s_axi_bvalid_out && s_axi_awready_out && s_axi_wready_out) else $error("write not closed");
	a_write_busy: assert property (take_w |=> !s_axi_awready_out && !s_axi_wready_out)
		else $error("write taken while busy");
	a_read_answer: assert property (take_r |=> s_axi_rvalid_out) else $error("read answer late");
	a_read_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
		else $error("read data not held");
	a_read_close: assert property (s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out && s_axi_arready_out)
		else $error("read not closed");
	a_read_refuse: assert property (take_r && bad_a |=> s_axi_rresp_out == SSP_RESP_ERR && s_axi_rdata_out == 32'h0)
		else $error("bad address not refused");
	a_read_okay: assert property (take_r && !bad_a |=> s_axi_rresp_out == SSP_RESP_OK) else $error("good read refused");
	a_master_pins: assert property ($rose(sclk_out) |-> sclk_oe_out && fss_oe_out)
		else $error("clock edge without master drive");
	c_write: cover property (take_w);
	c_refused: cover property (take_r && bad_a);
	c_clock: cover property ($rose(sclk_out));
endmodule
bind ssp_top ssp_properties u_props (.clock_in, .rst_b_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in,
	.s_axi_wready_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_bresp_out, .s_axi_arvalid_in, .s_axi_arready_out,
	.s_axi_araddr_in, .s_axi_rvalid_out, .s_axi_rready_in, .s_axi_rdata_out, .s_axi_rresp_out, .sclk_out,
	.sclk_oe_out, .fss_oe_out);
`default_nettype wire

// >>> verif/ssp_peer_model.sv
// peripheral chip on the serial side, shifting both ways
`timescale 1ns/1ps
`default_nettype none
module ssp_peer_model (
	input wire logic        sclk_in,
	input wire logic        fss_in,
	input wire logic        txd_in,
	input wire logic [1:0]  fmt_in,
	input wire logic [15:0] reply_in,
	output logic            rxd_out,
	output logic [15:0]     got_out
);
	logic [15:0] sh_r = 16'h0000;
	always @(negedge fss_in) if (fmt_in != 2'h1) begin
		sh_r = reply_in;
		got_out = 16'h0000;
	end
	always @(sclk_in) begin
		if (fmt_in == 2'h1 && fss_in) begin
			sh_r = reply_in;
			got_out = 16'h0000;
		end else if (sclk_in == (fmt_in != 2'h1)) begin
			got_out = {got_out[14:0], txd_in};
		end else begin
			sh_r = {sh_r[14:0], 1'b0};
		end
	end
	// deselected line flips so a stale bit never reads as good
	assign rxd_out = (fmt_in != 2'h1 && fss_in) ? ~sh_r[15] : sh_r[15];
endmodule
`default_nettype wire

// >>> verif/testbench.sv
// self-checking bench for the synchronous serial port
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import ssp_pkg::*;
	logic        clk = 1'b0, rst_b = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
	logic        fss_tb = 1'b1, sck_q = 1'b0, awr, wrd, bv, arr, rv, sck, sck_oe, fs, fs_oe, txd, txd_oe, rxd;
	logic        sck_tb = 1'b0;
	logic [4:0]  awa = 5'h00, ara = 5'h00;
	logic [31:0] wd = 32'h0, s_rd, v;
	logic [1:0]  brsp, rrsp, vr, fmt = 2'h0;
	logic [15:0] reply = 16'h0, got, m;
	int          n_fail = 0, cmp_count = 0, hp = 0, hp_cnt = 0;
	wire         sck_w = sck_oe ? sck : sck_tb;
	// a released data line shows the inverse so a stale bit never reads as good
	wire         txd_w = txd_oe ? txd : ~txd;
	wire         fs_w = fs_oe ? fs : fss_tb;
	always #4 clk = ~clk;
	// clocks per sclk half period, to check the divider
	always @(posedge clk) begin
		sck_q <= sck;
		hp_cnt <= (sck != sck_q) ? 1 : hp_cnt + 1;
		if (sck != sck_q) hp <= hp_cnt;
	end
	ssp_top u_dut (.clock_in(clk), .rst_b_in(rst_b), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
		.s_axi_awaddr_in(awa), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrd), .s_axi_wdata_in(wd),
		.s_axi_wstrb_in(4'hF), .s_axi_bvalid_out(bv), .s_axi_bready_in(bry), .s_axi_bresp_out(brsp),
		.s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_araddr_in(ara), .s_axi_rvalid_out(rv),
		.s_axi_rready_in(rry), .s_axi_rdata_out(s_rd), .s_axi_rresp_out(rrsp), .sclk_in(sck_w), .sclk_out(sck),
		.sclk_oe_out(sck_oe), .fss_in(fs_w), .fss_out(fs), .fss_oe_out(fs_oe), .rxd_in(rxd), .txd_out(txd),
		.txd_oe_out(txd_oe));
	ssp_peer_model u_peer (.sclk_in(sck_w), .fss_in(fs_w), .txd_in(txd_w), .fmt_in(fmt), .reply_in(reply),
		.rxd_out(rxd), .got_out(got));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// answers are accepted one cycle late so the hold side gets exercised
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		int t;
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		for (t = 0; t < 99; t++) begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wrd) wv <= 1'b0;
			if (bv && bry) break;
			if (bv) bry <= 1'b1;
		end
		vr = brsp;
		bry <= 1'b0;
		if (t == 99) n_fail++;
	endtask
	task automatic rd(input logic [4:0] a);
		int t;
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		for (t = 0; t < 99; t++) begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
			if (rv && rry) break;
			if (rv) rry <= 1'b1;
		end
		v = s_rd;
		vr = rrsp;
		rry <= 1'b0;
		if (t == 99) n_fail++;
	endtask
	task automatic idle;
		int t;
		for (t = 0; t < 300; t++) begin
			rd(SSP_STAT_OFF);
			if (v[SSP_ST_TFE] && !v[SSP_ST_BSY]) break;
		end
	endtask
	task automatic xfer(input logic [1:0] f, input logic [3:0] sz, input logic [7:0] sc, input logic [15:0] tx);
		fmt = f;
		wr(SSP_CTRL0_OFF, {16'h0000, sc, 2'h0, f, sz});
		wr(SSP_DATA_OFF, {16'h0000, tx});
		idle;
		rd(SSP_DATA_OFF);
	endtask
	task automatic t_reset;
		logic [31:0] e [5] = '{32'h7, 32'h0, 32'h0, 32'h3, 32'h2};
		for (int i = 0; i < 5; i++) begin
			rd(5'(i * 4));
			chk("reset value", e[i], v);
		end
		rd(5'h14);
		chk("unmapped data", 32'h0, v);
		rd(5'h06);
		chk("unaligned resp", 32'h2, {30'h0, vr});
		wr(5'h14, 32'hFFFFFFFF);
		chk("unmapped write", 32'h2, {30'h0, vr});
	endtask
	task automatic t_formats;
		reply = 16'h5A00;
		wr(SSP_PRESC_OFF, 32'h8);
		wr(SSP_CTRL1_OFF, 32'h2);
		for (int f = 0; f < 3; f++) begin
			xfer(2'(f), 4'h7, 8'h00, 16'h00C3);
			chk("peer word", 32'hC3, {24'h0, (f == 2) ? got[15:8] : got[7:0]});
			if (f == 0) chk("rx word", 32'h5A, v);
		end
		chk("half period", 32'h4, hp);
	endtask
	task automatic t_sizes;
		int n;
		reply = 16'hE71D;
		wr(SSP_PRESC_OFF, 32'h6);
		for (int i = 0; i < 2; i++) begin
			n = i ? 16 : 4;
			m = 16'hFFFF >> (16 - n);
			xfer(2'h0, 4'(n - 1), 8'h01, 16'hB3C9);
			chk("peer bits", {16'h0, 16'hB3C9 & m}, {16'h0, got & m});
			chk("rx bits", {16'h0, 16'hE71D >> (16 - n)}, v);
		end
		chk("half period", 32'h6, hp);
	endtask
	task automatic t_queues;
		wr(SSP_CTRL1_OFF, 32'h0);
		wr(SSP_CTRL0_OFF, 32'h3);
		reply = 16'hE000;
		for (int i = 0; i < 9; i++) wr(SSP_DATA_OFF, 32'(i));
		rd(SSP_STAT_OFF);
		chk("tx full status", 32'h10, v);
		wr(SSP_CTRL1_OFF, 32'h2);
		idle;
		rd(SSP_STAT_OFF);
		chk("rx full status", 32'hF, v);
		reply = 16'h3000;
		wr(SSP_DATA_OFF, 32'h5);
		idle;
		rd(SSP_STAT_OFF);
		chk("overrun status", 32'h2F, v);
		for (int i = 0; i < 8; i++) begin
			rd(SSP_DATA_OFF);
			chk("kept rx word", 32'hE, v);
		end
		wr(SSP_STAT_OFF, 32'h20);
		rd(SSP_STAT_OFF);
		chk("cleared status", 32'h3, v);
	endtask
	task automatic t_slave;
		wr(SSP_CTRL1_OFF, 32'h6);
		reply = 16'h5000;
		wr(SSP_DATA_OFF, 32'hA);
		fss_tb <= 1'b0;
		repeat (8) @(posedge clk);
		chk("slave drive", 32'h1, {31'h0, txd_oe});
		chk("slave clock", 32'h0, {31'h0, sck_oe});
		// outside master at four module clocks per half period, the fastest a slave can follow
		repeat (8) begin
			sck_tb <= ~sck_tb;
			repeat (4) @(posedge clk);
		end
		fss_tb <= 1'b1;
		repeat (8) @(posedge clk);
		chk("slave peer word", 32'hA, {16'h0, got});
		rd(SSP_DATA_OFF);
		chk("slave rx word", 32'h5, v);
		wr(SSP_CTRL1_OFF, 32'hE);
		fss_tb <= 1'b0;
		repeat (8) @(posedge clk);
		chk("slave quiet", 32'h0, {31'h0, txd_oe});
		fss_tb <= 1'b1;
	endtask
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		t_reset;
		t_formats;
		t_sizes;
		t_queues;
		t_slave;
		summarize;
	end
	initial begin
		repeat (60000) @(posedge clk);
		n_fail++;
		summarize;
	end
endmodule
`default_nettype wire
